//--- rtl/fsw_params.svh
/*
 * Constants of the single-byte flash write path: register offsets, field
 * positions, reset values, flash opcodes and timing counts.
 * Assumes a 20 MHz system clock; included by bare name.
 */
`ifndef FSW_PARAMS_SVH
`define FSW_PARAMS_SVH

// system clock period and serial clock half period, in ns
`define FSW_CLK_NS          50
`define FSW_SCK_HALF_NS     100
// least time rounds up to whole cycles
`define FSW_SCK_HALF_CYC    ((`FSW_SCK_HALF_NS + `FSW_CLK_NS - 1) / `FSW_CLK_NS)
`define FSW_DIV_W           4

// abort flag length in clock cycles
`define FSW_ABORT_CYC       2'h2

// register offsets (byte addresses on the plain register port)
`define FSW_REG_STATUS      4'h0
`define FSW_REG_MASK        4'h4
`define FSW_REG_PROT_CTRL   4'h8
`define FSW_REG_PROT_BASE   4'hC

// status / mask field positions
`define FSW_BIT_DONE        0
`define FSW_BIT_ABORT       1
`define FSW_BIT_BUSY        8
`define FSW_EVT_W           2

// reset values
`define FSW_MASK_RST        2'h0
`define FSW_PROT_EN_RST     1'h0
`define FSW_PROT_BASE_RST   24'hFFFFFF

// serial flash opcodes and status field
`define FSW_OP_WR_ENABLE    8'h06
`define FSW_OP_PROGRAM      8'h02
`define FSW_OP_RD_STATUS    8'h05
`define FSW_WIP_BIT         0

// serial frame lengths in bits
`define FSW_LEN_WEN         6'h08
`define FSW_LEN_PROG        6'h28
`define FSW_LEN_POLL        6'h10

`endif

//--- rtl/fsw_pkg.sv
/*
 * Types of the single-byte flash write path.
 * Assumes fsw_params.svh is on the include path.
 */
`include "fsw_params.svh"

package fsw_pkg;
	typedef logic [23:0] fsw_addr_t;
	typedef logic [7:0]  fsw_byte_t;
	typedef logic [3:0]  fsw_reg_addr_t;
	typedef logic [31:0] fsw_word_t;
	typedef logic [39:0] fsw_frame_t;
	typedef logic [5:0]  fsw_nbits_t;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_CHECK = 5'h02,
		ST_WEN   = 5'h04,
		ST_PROG  = 5'h08,
		ST_POLL  = 5'h10
	} fsw_state_t;
endpackage

//--- rtl/fsw_ser_if.sv
/*
 * Frame request/answer bundle between the write sequencer and the serial engine.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps

interface fsw_ser_if;
	import fsw_pkg::*;
	logic       start;
	fsw_frame_t tx;
	fsw_nbits_t nbits;
	logic       done;
	fsw_byte_t  rx;

	modport ctl (output start, output tx, output nbits, input done, input rx);
	modport eng (input start, input tx, input nbits, output done, output rx);
endinterface

//--- rtl/fsw_ser_engine.sv
/*
 * Serial engine: shifts out nbits of tx, MSB first, in one chip-select frame,
 * and keeps the last eight bits sampled from the flash data line.
 * Assumes start only while idle; serial clock is mode 0 from an enable divider.
 */
`timescale 1ns/1ps
`include "fsw_params.svh"

module fsw_ser_engine
	import fsw_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	fsw_ser_if.eng    ser,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      mosi_o,
	input  wire logic miso_i
);
	import fsw_pkg::*;

	localparam logic [`FSW_DIV_W-1:0] HALF = `FSW_DIV_W'(`FSW_SCK_HALF_CYC - 1);

	logic [`FSW_DIV_W-1:0] div_ff;
	logic                  tick;
	logic                  act_ff;
	fsw_frame_t            sh_ff;
	fsw_nbits_t            cnt_ff;
	fsw_byte_t             rx_ff;
	logic                  done_ff;

	assign tick    = (div_ff == HALF);
	assign ser.rx   = rx_ff;
	assign ser.done = done_ff;

	// divider runs only inside a frame so the first edge is a full half period away
	always_ff @(posedge clk_i) begin
		if (rst_i || !act_ff || tick) begin
			div_ff <= '0;
		end else begin
			div_ff <= div_ff + `FSW_DIV_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			act_ff  <= 1'b0;
			sclk_o  <= 1'b0;
			cs_n_o  <= 1'b1;
			mosi_o  <= 1'b0;
			sh_ff   <= '0;
			cnt_ff  <= '0;
			rx_ff   <= '0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (!act_ff) begin
				if (ser.start) begin
					act_ff <= 1'b1;
					cs_n_o <= 1'b0;
					mosi_o <= ser.tx[39];
					sh_ff  <= {ser.tx[38:0], 1'b0};
					cnt_ff <= ser.nbits;
				end
			end else if (tick) begin
				if (!sclk_o) begin
					sclk_o <= 1'b1;
					rx_ff  <= {rx_ff[6:0], miso_i};
				end else begin
					sclk_o <= 1'b0;
					mosi_o <= sh_ff[39];
					sh_ff  <= {sh_ff[38:0], 1'b0};
					cnt_ff <= cnt_ff - 6'h01;
					if (cnt_ff == 6'h01) begin
						act_ff  <= 1'b0;
						cs_n_o  <= 1'b1;
						done_ff <= 1'b1;
					end
				end
			end
		end
	end

	a_frame_end: assert property (@(posedge clk_i) disable iff (rst_i)
		done_ff |-> cs_n_o && !sclk_o)
		else $error("frame done while chip select still active");
endmodule

//--- rtl/fsw_top.sv
/*
 * Single-byte write path to a serial configuration flash: takes one byte and a
 * 24-bit address from user logic, checks protection, runs write-enable,
 * program and status polling, and reports busy and a two-cycle abort flag.
 * Assumes user inputs synchronous to clk_i and a mode-0 serial flash.
 */
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "fsw_params.svh"

module fsw_top
	import fsw_pkg::*;
(
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          write_i,
	input  wire logic          wren_i,
	input  wire fsw_pkg::fsw_byte_t     data_i,
	input  wire fsw_pkg::fsw_addr_t     addr_i,
	output logic               busy_o,
	output logic               abort_o,
	input  wire fsw_pkg::fsw_reg_addr_t reg_addr_i,
	input  wire fsw_pkg::fsw_word_t     reg_wdata_i,
	input  wire logic          reg_we_i,
	input  wire logic          reg_re_i,
	output fsw_pkg::fsw_word_t reg_rdata_o,
	output logic               irq_o,
	output logic               sclk_o,
	output logic               cs_n_o,
	output logic               mosi_o,
	input  wire logic          miso_i
);
	import fsw_pkg::*;

	fsw_ser_if ser ();

	fsw_state_t                state_ff;
	fsw_state_t                nxt_state;
	fsw_byte_t                 data_ff;
	fsw_addr_t                 addr_ff;
	logic                      req_ff;
	logic [1:0]                abort_cnt_ff;
	logic                      start_ff;
	fsw_frame_t                tx_ff;
	fsw_nbits_t                nbits_ff;
	logic [`FSW_EVT_W-1:0]     sts_ff;
	logic [`FSW_EVT_W-1:0]     mask_ff;
	logic                      prot_en_ff;
	fsw_addr_t                 prot_base_ff;
	logic                      accept;
	logic                      prot_hit;
	logic                      prog_done;
	logic                      abort_evt;
	logic [`FSW_EVT_W-1:0]     evt;
	logic [`FSW_EVT_W-1:0]     clr;

	assign ser.start = start_ff;
	assign ser.tx    = tx_ff;
	assign ser.nbits = nbits_ff;

	fsw_ser_engine u_engine (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.ser    (ser),
		.sclk_o (sclk_o),
		.cs_n_o (cs_n_o),
		.mosi_o (mosi_o),
		.miso_i (miso_i)
	);

	// only sampled in idle, so a request during busy never reaches the capture
	assign accept    = (state_ff == ST_IDLE) && write_i && wren_i;
	// judged on the captured address, so a late change of addr_i cannot slip past
	assign prot_hit  = prot_en_ff && (addr_ff >= prot_base_ff);
	assign prog_done = (state_ff == ST_POLL) && ser.done && !ser.rx[`FSW_WIP_BIT];
	assign abort_evt = (state_ff == ST_CHECK) && prot_hit;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (accept) begin
					nxt_state = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (prot_hit) begin
					nxt_state = ST_IDLE;
				end else begin
					nxt_state = ST_WEN;
				end
			end
			ST_WEN: begin
				if (ser.done) begin
					nxt_state = ST_PROG;
				end
			end
			ST_PROG: begin
				if (ser.done) begin
					nxt_state = ST_POLL;
				end
			end
			ST_POLL: begin
				if (prog_done) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// request capture: the byte comes straight from the data input, no load strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_ff <= '0;
			addr_ff <= '0;
			req_ff  <= 1'b0;
		end else begin
			req_ff <= accept;
			if (accept) begin
				data_ff <= data_i;
				addr_ff <= addr_i;
			end
		end
	end

	// accept needs idle, so a set and a clear of busy never meet in one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_o <= 1'b0;
		end else if (accept) begin
			busy_o <= 1'b1;
		end else if (abort_evt || prog_done) begin
			busy_o <= 1'b0;
		end
	end

	// abort flag length is counted, not shaped by the state machine
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			abort_cnt_ff <= 2'h0;
			abort_o      <= 1'b0;
		end else if (abort_evt) begin
			abort_cnt_ff <= `FSW_ABORT_CYC - 2'h1;
			abort_o      <= 1'b1;
		end else if (abort_cnt_ff != 2'h0) begin
			abort_cnt_ff <= abort_cnt_ff - 2'h1;
		end else begin
			abort_o <= 1'b0;
		end
	end

	// frame launch: a start pulse on entry into each serial state and on each repeated status poll
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			start_ff <= 1'b0;
			tx_ff    <= '0;
			nbits_ff <= '0;
		end else begin
			start_ff <= 1'b0;
			if (state_ff == ST_CHECK && !prot_hit) begin
				start_ff <= 1'b1;
				tx_ff    <= {`FSW_OP_WR_ENABLE, 32'h00000000};
				nbits_ff <= `FSW_LEN_WEN;
			end else if (state_ff == ST_WEN && ser.done) begin
				start_ff <= 1'b1;
				tx_ff    <= {`FSW_OP_PROGRAM, addr_ff, data_ff};
				nbits_ff <= `FSW_LEN_PROG;
			end else if ((state_ff == ST_PROG && ser.done) ||
				(state_ff == ST_POLL && ser.done && ser.rx[`FSW_WIP_BIT])) begin
				// keep polling while the flash still reports a write in progress
				start_ff <= 1'b1;
				tx_ff    <= {`FSW_OP_RD_STATUS, 32'h00000000};
				nbits_ff <= `FSW_LEN_POLL;
			end
		end
	end

	// software side: sticky events, mask, protection window
	assign evt = {abort_evt, prog_done};
	assign clr = (reg_we_i && reg_addr_i == `FSW_REG_STATUS) ?
		reg_wdata_i[`FSW_EVT_W-1:0] : '0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sts_ff <= '0;
		end else begin
			// a new event wins over a clear in the same cycle
			sts_ff <= (sts_ff & ~clr) | evt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_ff      <= `FSW_MASK_RST;
			prot_en_ff   <= `FSW_PROT_EN_RST;
			prot_base_ff <= `FSW_PROT_BASE_RST;
		end else if (reg_we_i) begin
			case (reg_addr_i)
				`FSW_REG_MASK: begin
					mask_ff <= reg_wdata_i[`FSW_EVT_W-1:0];
				end
				`FSW_REG_PROT_CTRL: begin
					prot_en_ff <= reg_wdata_i[0];
				end
				`FSW_REG_PROT_BASE: begin
					prot_base_ff <= reg_wdata_i[23:0];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(((sts_ff & ~clr) | evt) & mask_ff);
		end
	end

	// read data valid only in the cycle after the read strobe; unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= '0;
		end else if (reg_re_i) begin
			case (reg_addr_i)
				`FSW_REG_STATUS: begin
					reg_rdata_o <= {23'h0, busy_o, 6'h00, sts_ff};
				end
				`FSW_REG_MASK: begin
					reg_rdata_o <= {30'h0, mask_ff};
				end
				`FSW_REG_PROT_CTRL: begin
					reg_rdata_o <= {31'h0, prot_en_ff};
				end
				`FSW_REG_PROT_BASE: begin
					reg_rdata_o <= {8'h00, prot_base_ff};
				end
				default: begin
					reg_rdata_o <= '0;
				end
			endcase
		end else begin
			reg_rdata_o <= '0;
		end
	end

	a_gate_low_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_ff == ST_IDLE && write_i && !wren_i) |=> !busy_o && !req_ff)
		else $error("request with gate low was not ignored");

	a_protect_drop: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_ff == ST_CHECK && prot_hit) |=> !busy_o && !start_ff && state_ff == ST_IDLE)
		else $error("protected write was not dropped");

	a_abort_width: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(abort_o) |-> abort_o [*2] ##1 !abort_o)
		else $error("abort flag not exactly two cycles");

	a_capture_regs: assert property (@(posedge clk_i) disable iff (rst_i)
		accept |=> addr_ff == $past(addr_i) && data_ff == $past(data_i))
		else $error("address or byte not captured with request");

	a_busy_raise: assert property (@(posedge clk_i) disable iff (rst_i)
		accept |=> busy_o && state_ff == ST_CHECK)
		else $error("busy not raised after captured command");

	a_busy_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(busy_o) |-> $past(prog_done) || $past(abort_evt))
		else $error("busy fell before programming finished");

	a_restart_write: assert property (@(posedge clk_i) disable iff (rst_i)
		($fell(busy_o) && write_i && wren_i) |=> busy_o)
		else $error("held request did not start another write");

	a_busy_ignore: assert property (@(posedge clk_i) disable iff (rst_i)
		(busy_o && state_ff != ST_IDLE) |=> $stable(addr_ff) && $stable(data_ff))
		else $error("request captured while busy");

	a_direct_byte: assert property (@(posedge clk_i) disable iff (rst_i)
		(start_ff && nbits_ff == `FSW_LEN_PROG) |-> tx_ff[7:0] == data_ff &&
			tx_ff[31:8] == addr_ff)
		else $error("program frame does not carry captured byte");

	a_wen_first: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_ff == ST_CHECK && !prot_hit) |=> start_ff && tx_ff[39:32] == `FSW_OP_WR_ENABLE)
		else $error("write enable frame not launched after check");

	a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_o |-> |($past(sts_ff) | $past(evt)))
		else $error("interrupt without a status event");

	// busy and the state machine must agree, or a dropped command could hang the user
	a_idle_not_busy: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_ff == ST_IDLE) |-> !busy_o)
		else $error("busy high while sequencer idle");

	a_idle_no_frame: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_ff == ST_IDLE) |-> !start_ff)
		else $error("serial frame launched from idle");

	a_busy_in_flight: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_ff == ST_WEN || state_ff == ST_PROG || state_ff == ST_POLL) |-> busy_o)
		else $error("busy low while flash frames are running");

	a_abort_entry: assert property (@(posedge clk_i) disable iff (rst_i)
		abort_evt |=> abort_o && !busy_o)
		else $error("abort flag not raised with busy low");

	a_capture_busy: assert property (@(posedge clk_i) disable iff (rst_i)
		req_ff |-> busy_o)
		else $error("captured command without busy");

	a_busy_no_capture: assert property (@(posedge clk_i) disable iff (rst_i)
		busy_o |-> !accept)
		else $error("request accepted while busy");

	a_restart_accept: assert property (@(posedge clk_i) disable iff (rst_i)
		($fell(busy_o) && write_i && wren_i) |-> accept)
		else $error("held request not sampled at busy fall");
endmodule

//--- dv/fsw_flash_model.sv
/*
 * Behavioural serial flash for the write path: decodes write-enable, program
 * and status frames, and reports write-in-progress for a few status polls.
 * Assumes mode-0 framing from the block, MSB first, one frame per select.
 */
`timescale 1ns/1ps
`include "fsw_params.svh"

module fsw_flash_model #(
	parameter int WIP_POLLS = 2
) (
	input  wire logic sclk_i,
	input  wire logic cs_n_i,
	input  wire logic mosi_i,
	output logic      miso_o
);
	logic [39:0] shift;
	logic [39:0] last_prog;
	logic [7:0]  op;
	logic        wel      = 1'b0;
	int          nbit     = 0;
	int          wip_left = 0;
	int          n_wen    = 0;
	int          n_prog   = 0;
	int          n_poll   = 0;

	initial miso_o = 1'b0;

	always @(negedge cs_n_i) begin
		nbit = 0;
		op = 8'h00;
	end

	always @(posedge sclk_i) if (!cs_n_i) begin
		shift = {shift[38:0], mosi_i};
		nbit++;
		if (nbit == 8)
			op = shift[7:0];
	end

	// status bit goes out on the fall so it is settled at the next rise
	always @(negedge sclk_i) if (!cs_n_i && op == `FSW_OP_RD_STATUS && nbit >= 8)
		miso_o <= (nbit == 15) && (wip_left > 0);

	// like the real part, a program without a prior write-enable is dropped
	always @(posedge cs_n_i) begin
		miso_o <= ~miso_o;
		if (nbit == 8 && op == `FSW_OP_WR_ENABLE) begin
			wel = 1'b1;
			n_wen++;
		end
		if (nbit == 40 && op == `FSW_OP_PROGRAM && wel) begin
			last_prog = shift;
			n_prog++;
			wip_left = WIP_POLLS;
			wel = 1'b0;
		end
		if (nbit == 16 && op == `FSW_OP_RD_STATUS) begin
			n_poll++;
			if (wip_left > 0)
				wip_left--;
		end
	end
endmodule

//--- dv/fsw_top_bench.sv
/*
 * Self-checking bench of the single-byte flash write path: register and
 * command tasks against the top module, a serial flash model on the far side.
 * Assumes the design package, header and flash model are compiled first.
 */
`timescale 1ns/1ps
`include "fsw_params.svh"

module fsw_top_bench;
	import fsw_pkg::*;
	localparam int WIPS = 2;
	logic          clk_i       = 1'b0;
	logic          rst_i       = 1'b1;
	logic          write_i     = 1'b0;
	logic          wren_i      = 1'b0;
	fsw_byte_t     data_i      = 8'h00;
	fsw_addr_t     addr_i      = 24'h000000;
	fsw_reg_addr_t reg_addr_i  = 4'h0;
	fsw_word_t     reg_wdata_i = 32'h00000000;
	logic          reg_we_i    = 1'b0;
	logic          reg_re_i    = 1'b0;
	logic          busy_o;
	logic          abort_o;
	fsw_word_t     reg_rdata_o;
	logic          irq_o;
	logic          sclk_o;
	logic          cs_n_o;
	logic          mosi_o;
	logic          miso_i;
	fsw_word_t     rd;
	int            p0;
	int            n_mismatch  = 0;
	int            num_checks  = 0;
	int            cycles      = 0;

	always #25 clk_i = ~clk_i;

	fsw_top DUT (.clk_i(clk_i), .rst_i(rst_i), .write_i(write_i), .wren_i(wren_i),
		.data_i(data_i), .addr_i(addr_i), .busy_o(busy_o), .abort_o(abort_o),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
		.reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
		.sclk_o(sclk_o), .cs_n_o(cs_n_o), .mosi_o(mosi_o), .miso_i(miso_i));

	fsw_flash_model #(.WIP_POLLS(WIPS)) FLASH (.sclk_i(sclk_o), .cs_n_i(cs_n_o),
		.mosi_i(mosi_o), .miso_o(miso_i));

	task automatic chk(input string what, input fsw_word_t exp, input fsw_word_t got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic reg_wr(input fsw_reg_addr_t a, input fsw_word_t d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1'b1;
		@(posedge clk_i);
		reg_we_i <= 1'b0;
	endtask

	task automatic rd_chk(input string what, input fsw_reg_addr_t a, input fsw_word_t exp);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_re_i <= 1'b1;
		@(posedge clk_i);
		reg_re_i <= 1'b0;
		#1 chk(what, exp, reg_rdata_o);
	endtask

	// inputs are scrambled after the accepting edge unless the request is held
	task automatic cmd(input fsw_addr_t a, input fsw_byte_t d, input bit keep);
		@(posedge clk_i);
		data_i <= d;
		addr_i <= a;
		@(posedge clk_i);
		write_i <= 1'b1;
		wren_i <= 1'b1;
		@(posedge clk_i);
		if (!keep) begin
			write_i <= 1'b0;
			wren_i <= 1'b0;
			data_i <= ~d;
			addr_i <= ~a;
		end
		#1 chk("busy after accept", 1, busy_o);
	endtask

	task automatic wait_idle();
		for (int i = 0; i < 3000 && busy_o !== 1'b0; i++) begin
			@(posedge clk_i);
			#1;
		end
	endtask

	task automatic tally_and_finish();
		if (n_mismatch == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// a full run needs under two thousand cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk("status reset", `FSW_REG_STATUS, 32'h0);
		rd_chk("mask reset", `FSW_REG_MASK, 32'h0);
		rd_chk("prot ctrl reset", `FSW_REG_PROT_CTRL, 32'h0);
		rd_chk("prot base reset", `FSW_REG_PROT_BASE, {8'h00, `FSW_PROT_BASE_RST});
		rd_chk("unmapped read", 4'h2, 32'h0);
		// gate low with the request held
		@(posedge clk_i);
		write_i <= 1'b1;
		repeat (20) begin
			@(posedge clk_i);
			#1 chk("busy gate low", 0, busy_o);
		end
		@(posedge clk_i);
		write_i <= 1'b0;
		chk("frames gate low", 0, FLASH.n_wen);
		cmd(24'h123456, 8'hA5, 1'b0);
		wait_idle();
		chk("wip at busy fall", 0, FLASH.wip_left);
		chk("polls", WIPS + 1, FLASH.n_poll);
		chk("programs", 1, FLASH.n_prog);
		chk("prog addr", 24'h123456, FLASH.last_prog[31:8]);
		chk("prog byte", 8'hA5, FLASH.last_prog[7:0]);
		rd_chk("status done", `FSW_REG_STATUS, 32'h1 << `FSW_BIT_DONE);
		chk("irq masked", 0, irq_o);
		reg_wr(`FSW_REG_MASK, 32'h3);
		@(posedge clk_i);
		#1 chk("irq raised", 1, irq_o);
		reg_wr(`FSW_REG_STATUS, 32'h1);
		@(posedge clk_i);
		#1 chk("irq cleared", 0, irq_o);
		rd_chk("status cleared", `FSW_REG_STATUS, 32'h0);
		// request held through busy: ignored while busy, restarted at the fall
		cmd(24'h000100, 8'h5A, 1'b1);
		wait_idle();
		chk("no extra while busy", 2, FLASH.n_prog);
		@(posedge clk_i);
		write_i <= 1'b0;
		wren_i <= 1'b0;
		#1 chk("restart", 1, busy_o);
		wait_idle();
		chk("one more only", 3, FLASH.n_prog);
		reg_wr(`FSW_REG_STATUS, 32'h3);
		// protected from the base upward, the base itself included
		reg_wr(`FSW_REG_PROT_BASE, 32'h00200000);
		reg_wr(`FSW_REG_PROT_CTRL, 32'h1);
		p0 = FLASH.n_wen;
		cmd(24'h200000, 8'hC3, 1'b0);
		@(posedge clk_i);
		#1 chk("busy on abort", 0, busy_o);
		chk("abort first", 1, abort_o);
		@(posedge clk_i);
		#1 chk("abort second", 1, abort_o);
		@(posedge clk_i);
		#1 chk("abort end", 0, abort_o);
		chk("no flash frame", p0, FLASH.n_wen);
		rd_chk("status abort", `FSW_REG_STATUS, 32'h1 << `FSW_BIT_ABORT);
		chk("irq abort", 1, irq_o);
		cmd(24'h1FFFFF, 8'h81, 1'b0);
		wait_idle();
		chk("below base", 4, FLASH.n_prog);
		chk("below base addr", 24'h1FFFFF, FLASH.last_prog[31:8]);
		tally_and_finish();
	end
endmodule
